// file: rtl/gpp_pkg.sv
package gpp_pkg;
    localparam int unsigned NPIN      = 8;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned REG_W     = 8;
    // register byte offsets
    localparam logic [7:0]  DIR_BASE   = 8'h00;  // +0 value, +4 set, +8 clear, +c toggle
    localparam logic [7:0]  OUT_BASE   = 8'h10;
    localparam logic [7:0]  PULL_BASE  = 8'h20;
    localparam logic [7:0]  IN_OFF     = 8'h30;
    localparam logic [7:0]  MASK0_OFF  = 8'h34;
    localparam logic [7:0]  MASK1_OFF  = 8'h38;
    localparam logic [7:0]  FLAGS_OFF  = 8'h3c;
    localparam logic [7:0]  MPC_OFF    = 8'h40;
    localparam logic [7:0]  CTLALL_OFF = 8'h44;
    localparam logic [7:0]  OUTSEL_OFF = 8'h48;
    localparam logic [7:0]  REMAP_OFF  = 8'h4c;
    localparam logic [7:0]  PCTL_BASE  = 8'h60;  // + 4 * pin
    // sub-operation within a group, taken from address bits 3:2
    localparam logic [1:0]  OP_VAL = 2'h0;
    localparam logic [1:0]  OP_SET = 2'h1;
    localparam logic [1:0]  OP_CLR = 2'h2;
    localparam logic [1:0]  OP_TGL = 2'h3;
    // fixed pins for clock and event output
    localparam logic [2:0]  CLK_PIN = 3'h7;
    localparam logic [2:0]  RTC_PIN = 3'h6;
    localparam logic [2:0]  EV_PIN  = 3'h5;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [7:0]  REG_RST = 8'h00;

    typedef enum logic [1:0] {
        GPP_SNS_BOTH = 2'h0,
        GPP_SNS_RISE = 2'h1,
        GPP_SNS_FALL = 2'h2,
        GPP_SNS_LOW  = 2'h3
    } gpp_sense_t;

    typedef enum logic [1:0] {
        GPP_DRV_TOTEM  = 2'h0,
        GPP_DRV_WOR    = 2'h1,
        GPP_DRV_WAND   = 2'h2,
        GPP_DRV_KEEPER = 2'h3
    } gpp_drive_t;

    // pin control register layout, bit 6 down to bit 0
    typedef struct packed {
        logic       invert;
        logic       slew;
        logic       pull_up;
        gpp_drive_t drive;
        gpp_sense_t sense;
    } gpp_pctl_t;

    typedef struct packed {
        logic       clk_en;
        logic       rtc_en;
        logic       ev_en;
        logic [2:0] ev_sel;
    } gpp_outsel_t;
endpackage : gpp_pkg

// file: rtl/gpp_port.sv
`timescale 1ns/1ns
module gpp_port
    import gpp_pkg::*;
(
    input  wire  logic                CORE_CLK,
    input  wire  logic                RST_B,
    input  wire  logic [ADDR_W-1:0]   S_AXI_AWADDR,
    input  wire  logic                S_AXI_AWVALID,
    output logic                      S_AXI_AWREADY,
    input  wire  logic [31:0]         S_AXI_WDATA,
    input  wire  logic [3:0]          S_AXI_WSTRB,
    input  wire  logic                S_AXI_WVALID,
    output logic                      S_AXI_WREADY,
    output logic [1:0]                S_AXI_BRESP,
    output logic                      S_AXI_BVALID,
    input  wire  logic                S_AXI_BREADY,
    input  wire  logic [ADDR_W-1:0]   S_AXI_ARADDR,
    input  wire  logic                S_AXI_ARVALID,
    output logic                      S_AXI_ARREADY,
    output logic [31:0]               S_AXI_RDATA,
    output logic [1:0]                S_AXI_RRESP,
    output logic                      S_AXI_RVALID,
    input  wire  logic                S_AXI_RREADY,
    input  wire  logic [NPIN-1:0]     PIN_I,
    output logic [NPIN-1:0]           PIN_O,
    output logic [NPIN-1:0]           PIN_OE_B,
    output logic [NPIN-1:0]           PIN_PULL_UP,
    output logic [NPIN-1:0]           PIN_PULL_DN,
    output logic [NPIN-1:0]           PIN_SLEW,
    input  wire  logic                PORT_CLK_EN,
    input  wire  logic                RTC_CLK,
    input  wire  logic [7:0]          EVENT_CH,
    input  wire  logic [NPIN-1:0]     ALT_O,
    input  wire  logic [NPIN-1:0]     ALT_OE,
    output logic [NPIN-1:0]           ALT_IN,
    output logic [NPIN-1:0]           PIN_EVENT,
    output logic                      IRQ0,
    output logic                      IRQ1,
    output logic                      WAKE
);

    typedef struct packed {
        logic                  aw_free;
        logic [ADDR_W-1:0]     aw_addr;
        logic                  w_free;
        logic [REG_W-1:0]      w_data;
        logic                  w_lane;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  ar_free;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [NPIN-1:0]       dir;
        logic [NPIN-1:0]       outv;
        logic [NPIN-1:0]       pull_en;
        logic [NPIN-1:0]       mask0;
        logic [NPIN-1:0]       mask1;
        logic [NPIN-1:0]       flags;
        logic [NPIN-1:0]       mpc;
        gpp_outsel_t           outsel;
        logic [3:0]            remap;
        gpp_pctl_t [NPIN-1:0]  pctl;
        logic [NPIN-1:0]       sync1;
        logic [NPIN-1:0]       sync2;
        logic [NPIN-1:0]       prev;
        logic                  rtc1;
        logic                  rtc2;
        logic                  clk_div;
        logic [NPIN-1:0]       pin_o;
        logic [NPIN-1:0]       pin_oe_b;
        logic [NPIN-1:0]       pu;
        logic [NPIN-1:0]       pd;
        logic [NPIN-1:0]       slew;
        logic [NPIN-1:0]       alt_in;
        logic [NPIN-1:0]       evt;
        logic                  irq0;
        logic                  irq1;
        logic                  wake;
    } gpp_state_t;

    gpp_state_t s;
    gpp_state_t next_s;

    logic [NPIN-1:0] in_val;
    logic [NPIN-1:0] detect;
    logic [NPIN-1:0] drv_o;
    logic [NPIN-1:0] drv_oe_b;
    logic [NPIN-1:0] drv_pu;
    logic [NPIN-1:0] drv_pd;
    logic [NPIN-1:0] route_in;

    // per pin sensing and driver logic
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        localparam int unsigned PAIR = (i + 4) % 8;
        logic       swap;
        logic       src;
        logic       val;
        logic       rise;
        logic       fall;
        gpp_pctl_t  c;
        assign c        = s.pctl[i];
        assign swap     = s.remap[i % 4];
        assign in_val[i] = s.sync2[i] ^ c.invert;
        assign rise     = in_val[i] & ~s.prev[i];
        assign fall     = ~in_val[i] & s.prev[i];
        // without the port clock only the level and any-change checks stay meaningful
        always_comb begin
            unique case (c.sense)
                GPP_SNS_BOTH: detect[i] = rise | fall;
                GPP_SNS_RISE: detect[i] = PORT_CLK_EN ? rise : (rise | fall);
                GPP_SNS_FALL: detect[i] = PORT_CLK_EN ? fall : (rise | fall);
                GPP_SNS_LOW:  detect[i] = ~in_val[i];
            endcase
        end
        // peripheral supplies the output value when it asks for it; dir still sets the driver enable and clock/event selects win
        assign route_in[i] = swap ? in_val[PAIR] : in_val[i];
        assign src = (swap ? ALT_OE[PAIR] : ALT_OE[i]) ?
                     (swap ? ALT_O[PAIR] : ALT_O[i]) : s.outv[i];
        always_comb begin
            val = src;
            if (s.outsel.clk_en && i == int'(CLK_PIN)) begin
                val = s.clk_div;
            end
            if (s.outsel.rtc_en && i == int'(RTC_PIN)) begin
                val = s.rtc2;
            end
            if (s.outsel.ev_en && i == int'(EV_PIN)) begin
                val = EVENT_CH[s.outsel.ev_sel];
            end
        end
        assign drv_o[i] = val ^ c.invert;
        always_comb begin
            drv_oe_b[i] = 1'b1;
            drv_pu[i]   = 1'b0;
            drv_pd[i]   = 1'b0;
            unique case (c.drive)
                GPP_DRV_TOTEM: begin
                    drv_oe_b[i] = ~s.dir[i];
                    drv_pu[i]   = ~s.dir[i] & s.pull_en[i] & c.pull_up;
                    drv_pd[i]   = ~s.dir[i] & s.pull_en[i] & ~c.pull_up;
                end
                GPP_DRV_WOR: begin
                    drv_oe_b[i] = ~(s.dir[i] & drv_o[i]);
                    drv_pu[i]   = s.pull_en[i] & c.pull_up;
                    drv_pd[i]   = s.pull_en[i] & ~c.pull_up;
                end
                GPP_DRV_WAND: begin
                    drv_oe_b[i] = ~(s.dir[i] & ~drv_o[i]);
                    drv_pu[i]   = s.pull_en[i] & c.pull_up;
                    drv_pd[i]   = s.pull_en[i] & ~c.pull_up;
                end
                GPP_DRV_KEEPER: begin
                    // the pin level seen last stands in for the last driven level
                    drv_oe_b[i] = ~s.dir[i];
                    drv_pu[i]   = ~s.dir[i] & s.sync2[i];
                    drv_pd[i]   = ~s.dir[i] & ~s.sync2[i];
                end
            endcase
        end
    end

    function automatic logic [NPIN-1:0] atomic_read_modify_write(input logic [NPIN-1:0] cur,
                                            input logic [1:0]      op,
                                            input logic [NPIN-1:0] d);
        logic [NPIN-1:0] r;
        r = cur;
        unique case (op)
            OP_VAL: r = d;
            OP_SET: r = cur | d;
            OP_CLR: r = cur & ~d;
            OP_TGL: r = cur ^ d;
        endcase
        return r;
    endfunction : atomic_read_modify_write

    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [NPIN-1:0]   wd;
    logic              do_wr;
    logic              wr_ok;
    logic              rd_ok;
    logic [REG_W-1:0]  rd;

    always_comb begin
        next_s = s;
        wa     = s.aw_addr;
        ra     = S_AXI_ARADDR;
        wd     = s.w_data;
        do_wr  = ~s.aw_free & ~s.w_free & ~s.bvalid;
        wr_ok  = 1'b1;
        rd_ok  = 1'b1;
        rd     = REG_RST;

        next_s.sync1 = PIN_I;
        next_s.sync2 = s.sync1;
        next_s.prev  = in_val;
        next_s.rtc1  = RTC_CLK;
        next_s.rtc2  = s.rtc1;
        // core clock cannot leave a flop undivided, so half rate goes out
        next_s.clk_div = ~s.clk_div;

        if (S_AXI_AWVALID && s.aw_free) begin
            next_s.aw_free = 1'b0;
            next_s.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s.w_free) begin
            next_s.w_free = 1'b0;
            next_s.w_data = S_AXI_WDATA[REG_W-1:0];
            next_s.w_lane = S_AXI_WSTRB[0];
        end
        if (s.bvalid && S_AXI_BREADY) begin
            next_s.bvalid = 1'b0;
        end
        // hardware set wins over a software clear in the same cycle
        next_s.flags = s.flags | detect;

        if (do_wr) begin
            next_s.aw_free = 1'b1;
            next_s.w_free  = 1'b1;
            next_s.bvalid  = 1'b1;
            if (wa[1:0] != 2'h0) begin
                wr_ok = 1'b0;
            end else if (wa < IN_OFF) begin
                if (s.w_lane) begin
                    unique case (wa[5:4])
                        DIR_BASE[5:4]: next_s.dir = atomic_read_modify_write(s.dir, wa[3:2], wd);
                        OUT_BASE[5:4]: next_s.outv = atomic_read_modify_write(s.outv, wa[3:2], wd);
                        PULL_BASE[5:4]: next_s.pull_en = atomic_read_modify_write(s.pull_en, wa[3:2], wd);
                        default: wr_ok = 1'b0;
                    endcase
                end
            end else if (wa >= PCTL_BASE && wa < PCTL_BASE + 8'(4 * NPIN)) begin
                if (s.w_lane) begin
                    next_s.pctl[wa[4:2]] = gpp_pctl_t'(wd[6:0]);
                end
            end else if (s.w_lane) begin
                unique case (wa)
                    IN_OFF:     ;
                    MASK0_OFF:  next_s.mask0 = wd;
                    MASK1_OFF:  next_s.mask1 = wd;
                    FLAGS_OFF:  next_s.flags = (s.flags & ~wd) | detect;
                    MPC_OFF:    next_s.mpc = wd;
                    CTLALL_OFF: begin
                        for (int p = 0; p < NPIN; p++) begin
                            if (s.mpc[p]) begin
                                next_s.pctl[p] = gpp_pctl_t'(wd[6:0]);
                            end
                        end
                        next_s.mpc = '0;
                    end
                    OUTSEL_OFF: next_s.outsel = gpp_outsel_t'(wd[5:0]);
                    REMAP_OFF:  next_s.remap = wd[3:0];
                    default:    wr_ok = 1'b0;
                endcase
            end else begin
                unique case (wa)
                    IN_OFF, MASK0_OFF, MASK1_OFF, FLAGS_OFF, MPC_OFF,
                    CTLALL_OFF, OUTSEL_OFF, REMAP_OFF: ;
                    default: wr_ok = 1'b0;
                endcase
            end
            next_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end

        if (ra[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (ra < IN_OFF) begin
            unique case (ra[5:4])
                DIR_BASE[5:4]:  rd = s.dir;
                OUT_BASE[5:4]:  rd = s.outv;
                PULL_BASE[5:4]: rd = s.pull_en;
                default:        rd_ok = 1'b0;
            endcase
        end else if (ra >= PCTL_BASE && ra < PCTL_BASE + 8'(4 * NPIN)) begin
            rd = {1'b0, s.pctl[ra[4:2]]};
        end else begin
            unique case (ra)
                IN_OFF:     rd = in_val;
                MASK0_OFF:  rd = s.mask0;
                MASK1_OFF:  rd = s.mask1;
                FLAGS_OFF:  rd = s.flags;
                MPC_OFF:    rd = s.mpc;
                CTLALL_OFF: rd = REG_RST;
                OUTSEL_OFF: rd = {2'h0, s.outsel};
                REMAP_OFF:  rd = {4'h0, s.remap};
                default:    rd_ok = 1'b0;
            endcase
        end
        if (S_AXI_ARVALID && s.ar_free) begin
            next_s.ar_free = 1'b0;
            next_s.rvalid  = 1'b1;
            next_s.rdata   = {24'h000000, rd_ok ? rd : REG_RST};
            next_s.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s.rvalid && S_AXI_RREADY) begin
            next_s.rvalid  = 1'b0;
            next_s.ar_free = 1'b1;
        end

        next_s.pin_o    = drv_o;
        next_s.pin_oe_b = drv_oe_b;
        next_s.pu       = drv_pu;
        next_s.pd       = drv_pd;
        for (int p = 0; p < NPIN; p++) begin
            next_s.slew[p] = s.pctl[p].slew;
        end
        next_s.alt_in = route_in;
        next_s.evt    = detect;
        next_s.irq0   = |(next_s.flags & s.mask0);
        next_s.irq1   = |(next_s.flags & s.mask1);
        next_s.wake   = ~PORT_CLK_EN & |(detect & (s.mask0 | s.mask1));
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s          <= '0;
            s.aw_free  <= 1'b1;
            s.w_free   <= 1'b1;
            s.ar_free  <= 1'b1;
            s.pin_oe_b <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign S_AXI_AWREADY = s.aw_free;
    assign S_AXI_WREADY  = s.w_free;
    assign S_AXI_BVALID  = s.bvalid;
    assign S_AXI_BRESP   = s.bresp;
    assign S_AXI_ARREADY = s.ar_free;
    assign S_AXI_RVALID  = s.rvalid;
    assign S_AXI_RDATA   = s.rdata;
    assign S_AXI_RRESP   = s.rresp;
    assign PIN_O         = s.pin_o;
    assign PIN_OE_B      = s.pin_oe_b;
    assign PIN_PULL_UP   = s.pu;
    assign PIN_PULL_DN   = s.pd;
    assign PIN_SLEW      = s.slew;
    assign ALT_IN        = s.alt_in;
    assign PIN_EVENT     = s.evt;
    assign IRQ0          = s.irq0;
    assign IRQ1          = s.irq1;
    assign WAKE          = s.wake;

endmodule : gpp_port

// file: tb/gpp_port_properties.sv
`timescale 1ns/1ns
module gpp_port_properties
    import gpp_pkg::*;
(
    input wire logic            CORE_CLK,
    input wire logic            RST_B,
    input wire logic            S_AXI_AWVALID,
    input wire logic            S_AXI_AWREADY,
    input wire logic            S_AXI_WVALID,
    input wire logic            S_AXI_WREADY,
    input wire logic [1:0]      S_AXI_BRESP,
    input wire logic            S_AXI_BVALID,
    input wire logic            S_AXI_BREADY,
    input wire logic            S_AXI_ARVALID,
    input wire logic            S_AXI_ARREADY,
    input wire logic [31:0]     S_AXI_RDATA,
    input wire logic [1:0]      S_AXI_RRESP,
    input wire logic            S_AXI_RVALID,
    input wire logic            S_AXI_RREADY,
    input wire logic [NPIN-1:0] PIN_PULL_UP,
    input wire logic [NPIN-1:0] PIN_PULL_DN,
    input wire logic            PORT_CLK_EN,
    input wire logic            WAKE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    b_hold_a: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response withdrawn before taken");
    r_hold_a: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data withdrawn before taken");
    r_answer_a: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read not answered one cycle after address");
    r_width_a: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0 && S_AXI_RRESP != 2'h1)
        else $error("read data wider than eight pins");
    w_answer_a: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID
        |-> ##[1:2] S_AXI_BVALID)
        else $error("write not answered in time");
    aw_refuse_a: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("second write address accepted while one held");
    pull_excl_a: assert property (
        (PIN_PULL_UP & PIN_PULL_DN) == '0)
        else $error("pull-up and pull-down on together");
    wake_async_a: assert property (
        WAKE |-> !$past(PORT_CLK_EN) || !$past(PORT_CLK_EN, 2))
        else $error("wake raised in synchronous mode");
endmodule : gpp_port_properties

bind gpp_port gpp_port_properties u_props (.CORE_CLK, .RST_B, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .PIN_PULL_UP, .PIN_PULL_DN, .PORT_CLK_EN, .WAKE);

// file: tb/gpp_board.sv
`timescale 1ns/1ns
module gpp_board
    import gpp_pkg::*;
(
    input  wire logic [NPIN-1:0] pin_o,
    input  wire logic [NPIN-1:0] pin_oe_b,
    input  wire logic [NPIN-1:0] pull_up,
    input  wire logic [NPIN-1:0] pull_dn,
    input  wire logic [NPIN-1:0] ext_val,
    input  wire logic [NPIN-1:0] ext_en,
    input  wire logic            clk,
    output logic [NPIN-1:0]      pin_i
);
    logic [NPIN-1:0] last = '0;

    // a floating pin flips every cycle so it never looks like a settled level
    always @(posedge clk) begin
        last <= pin_i;
    end

    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (!pin_oe_b[i]) pin_i[i] = pin_o[i];
            else if (ext_en[i]) pin_i[i] = ext_val[i];
            else if (pull_up[i]) pin_i[i] = 1'b1;
            else if (pull_dn[i]) pin_i[i] = 1'b0;
            else pin_i[i] = ~last[i];
        end
    end
endmodule : gpp_board

// file: tb/gpp_port_bench.sv
`timescale 1ns/1ns
module gpp_port_bench
    import gpp_pkg::*;
;
    logic            clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic            bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic            port_clk_en = 1'b1, rtc_clk = 1'b0;
    logic [7:0]      awaddr = '0, araddr = '0, event_ch = '0, alt_o = '0, alt_oe = '0;
    logic [7:0]      ext_val = '0, ext_en = '0;
    logic [31:0]     wdata = '0, rdata;
    logic            awready, wready, bvalid, arready, rvalid, irq0, irq1, wake;
    logic [1:0]      bresp, rresp;
    logic [NPIN-1:0] pin_i, pin_o, pin_oe_b, pull_up, pull_dn, slew, alt_in, pin_event;
    int              fail_count = 0, cmp_count = 0, cycles = 0;

    gpp_port u_dut (.CORE_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_B(pin_oe_b),
        .PIN_PULL_UP(pull_up), .PIN_PULL_DN(pull_dn), .PIN_SLEW(slew),
        .PORT_CLK_EN(port_clk_en), .RTC_CLK(rtc_clk), .EVENT_CH(event_ch),
        .ALT_O(alt_o), .ALT_OE(alt_oe), .ALT_IN(alt_in), .PIN_EVENT(pin_event),
        .IRQ0(irq0), .IRQ1(irq1), .WAKE(wake));
    gpp_board u_board (.pin_o(pin_o), .pin_oe_b(pin_oe_b), .pull_up(pull_up),
        .pull_dn(pull_dn), .ext_val(ext_val), .ext_en(ext_en), .clk(clk), .pin_i(pin_i));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // the master waits for the slave however long it takes; only the timeout ends it
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", {24'h0, ed}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rchk

    task automatic s_map();
        rchk(DIR_BASE, 8'h00, RESP_OKAY);
        rchk(MASK0_OFF, 8'h00, RESP_OKAY);
        rchk(8'h50, 8'h00, RESP_SLVERR);
        wr(8'h51, 8'h01, RESP_SLVERR);
        chk("oe_b", 32'hff, {24'h0, pin_oe_b});
    endtask : s_map

    task automatic s_atomic();
        logic [7:0] b [3] = '{DIR_BASE, OUT_BASE, PULL_BASE};
        foreach (b[g]) begin
            wr(b[g], 8'h0f, RESP_OKAY);
            wr(b[g] + 8'h4, 8'h30, RESP_OKAY);
            wr(b[g] + 8'h8, 8'h01, RESP_OKAY);
            wr(b[g] + 8'hc, 8'h81, RESP_OKAY);
            rchk(b[g], 8'hbf, RESP_OKAY);
        end
        wr(PULL_BASE, 8'hff, RESP_OKAY);
        tick(3);
        chk("oe_b", 32'h40, {24'h0, pin_oe_b});
        chk("pin_o", 32'hbf, {24'h0, pin_o & 8'hbf});
        chk("pull_dn", 32'h40, {24'h0, pull_dn});
    endtask : s_atomic

    task automatic s_multi();
        wr(MPC_OFF, 8'h03, RESP_OKAY);
        wr(CTLALL_OFF, 8'h60, RESP_OKAY);
        rchk(PCTL_BASE + 8'h4, 8'h60, RESP_OKAY);
        rchk(PCTL_BASE + 8'h8, 8'h00, RESP_OKAY);
        rchk(MPC_OFF, 8'h00, RESP_OKAY);
        tick(3);
        chk("pin_o", 32'h0, {30'h0, pin_o[1:0]});
        chk("slew", 32'h3, {30'h0, slew[1:0]});
    endtask : s_multi

    task automatic s_sense();
        ext_val <= 8'hff;
        ext_en  <= 8'hff;
        wr(DIR_BASE, 8'h00, RESP_OKAY);
        wr(PCTL_BASE + 8'h4, 8'h41, RESP_OKAY);
        wr(PCTL_BASE + 8'h8, 8'h02, RESP_OKAY);
        wr(PCTL_BASE + 8'hc, 8'h03, RESP_OKAY);
        rchk(IN_OFF, 8'hfc, RESP_OKAY);
        wr(MASK0_OFF, 8'h0f, RESP_OKAY);
        wr(FLAGS_OFF, 8'hff, RESP_OKAY);
        rchk(FLAGS_OFF, 8'h00, RESP_OKAY);
        ext_val <= 8'hf0;
        tick(5);
        rchk(FLAGS_OFF, 8'h0f, RESP_OKAY);
        chk("irq", 32'h1, {30'h0, irq1, irq0});
        wr(FLAGS_OFF, 8'h0f, RESP_OKAY);
        tick(3);
        rchk(FLAGS_OFF, 8'h08, RESP_OKAY);
        chk("event", 32'h1, {31'h0, pin_event[3]});
        wr(MASK1_OFF, 8'h08, RESP_OKAY);
        wr(MASK0_OFF, 8'h00, RESP_OKAY);
        tick(2);
        chk("irq", 32'h2, {30'h0, irq1, irq0});
    endtask : s_sense

    task automatic s_async();
        logic seen;
        wr(MASK1_OFF, 8'h00, RESP_OKAY);
        wr(MASK0_OFF, 8'h01, RESP_OKAY);
        port_clk_en <= 1'b0;
        tick(4);
        seen = 1'b0;
        ext_val <= 8'hf1;
        repeat (8) begin
            @(posedge clk);
            seen |= (wake === 1'b1);
        end
        chk("wake", 32'h1, {31'h0, seen});
        port_clk_en <= 1'b1;
        tick(4);
        seen = 1'b0;
        ext_val <= 8'hf0;
        repeat (8) begin
            @(posedge clk);
            seen |= (wake !== 1'b0);
        end
        chk("wake", 32'h0, {31'h0, seen});
    endtask : s_async

    task automatic s_clkout();
        logic a;
        ext_en <= 8'h00;
        wr(DIR_BASE, 8'hff, RESP_OKAY);
        wr(OUTSEL_OFF, 8'h0a, RESP_OKAY);
        event_ch <= 8'h04;
        tick(3);
        chk("ev pin", 32'h1, {31'h0, pin_o[5]});
        event_ch <= 8'h00;
        tick(3);
        chk("ev pin", 32'h0, {31'h0, pin_o[5]});
        wr(OUTSEL_OFF, 8'h30, RESP_OKAY);
        rtc_clk <= 1'b1;
        tick(5);
        chk("rtc pin", 32'h1, {31'h0, pin_o[6]});
        a = pin_o[7];
        tick(1);
        chk("clk pin", {31'h0, ~a}, {31'h0, pin_o[7]});
    endtask : s_clkout

    task automatic s_remap();
        wr(OUTSEL_OFF, 8'h00, RESP_OKAY);
        alt_oe <= 8'h04;
        tick(3);
        chk("alt pin", 32'h0, {31'h0, pin_o[2]});
        alt_o <= 8'h04;
        wr(REMAP_OFF, 8'h04, RESP_OKAY);
        tick(4);
        chk("remap", 32'h3, {30'h0, pin_o[6], pin_o[2]});
        chk("alt in", 32'h1, {31'h0, alt_in[2]});
    endtask : s_remap

    // pin 4 wired-or with pull-up, pin 5 wired-and with pull-down, pin 7 keeper
    task automatic s_drive();
        wr(PCTL_BASE + 8'h10, 8'h14, RESP_OKAY);
        wr(PCTL_BASE + 8'h14, 8'h08, RESP_OKAY);
        wr(PCTL_BASE + 8'h1c, 8'h0c, RESP_OKAY);
        tick(3);
        chk("oe_b", 32'h2, {29'h0, pin_oe_b[7], pin_oe_b[5], pin_oe_b[4]});
        chk("pull_up", 32'h1, {29'h0, pull_up[7], pull_up[5], pull_up[4]});
        chk("pull_dn", 32'h2, {29'h0, pull_dn[7], pull_dn[5], pull_dn[4]});
        wr(OUT_BASE + 8'h8, 8'h30, RESP_OKAY);
        // pin 7 stops driving a one, so the keeper must pull it up
        wr(DIR_BASE + 8'h8, 8'h80, RESP_OKAY);
        tick(3);
        chk("oe_b", 32'h5, {29'h0, pin_oe_b[7], pin_oe_b[5], pin_oe_b[4]});
        chk("pull_up", 32'h5, {29'h0, pull_up[7], pull_up[5], pull_up[4]});
        chk("pull_dn", 32'h2, {29'h0, pull_dn[7], pull_dn[5], pull_dn[4]});
        chk("pin_o", 32'h0, {31'h0, pin_o[5]});
    endtask : s_drive

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        s_map();
        s_atomic();
        s_multi();
        s_sense();
        s_async();
        s_clkout();
        s_remap();
        s_drive();
        tick(2);
        test_done();
    end
endmodule : gpp_port_bench
